//--- core_model.sv
// behavioural model of the cpu core driven by the controller
`timescale 1ns/100ps
module core_model
  import irq_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic dev_rstn,
  input wire logic nmi_n,
  input wire logic sp_load,
  input wire logic [23:0] sp_value,
  input wire logic match_en,
  input wire logic [23:0] match_addr,
  input wire logic retire_tgl,
  input wire logic [23:0] retire_addr,
  input wire logic seq_valid,
  input wire logic [3:0] seq_op,
  input wire logic slow,
  output logic first_done,
  output logic nmi_port_bit,
  output logic seq_ack
);
  logic [23:0] sp = 24'h0;
  logic [3:0] ops[$];
  int nmi_count = 0;
  int hits = 0;
  int wait_cnt = 0;
  initial seq_ack = 1'b0;
  // input-only port bit: no output path, just the pin level
  assign nmi_port_bit = nmi_n;
  always @(posedge sys_clk or negedge dev_rstn) begin
    if (!dev_rstn) begin
      sp <= 24'h0;
      first_done <= 1'b0;
    end else begin
      first_done <= 1'b1;
      if (sp_load) begin
        sp <= sp_value;
      end
    end
  end
  // no mask exists here, every falling edge outside core reset is taken
  always @(negedge nmi_n) if (dev_rstn) nmi_count++;
  always @(retire_tgl) if (match_en && retire_addr == match_addr) hits++;
  // four-phase answer; slow mode delays both the rise and the fall of seq_ack
  always @(posedge sys_clk) begin
    if (seq_valid !== seq_ack) begin
      wait_cnt++;
      if (wait_cnt > (slow ? 6 : 0)) begin
        if (seq_valid) ops.push_back(seq_op);
        seq_ack <= seq_valid;
        wait_cnt = 0;
      end
    end
  end
endmodule

//--- irq_entry_host.sv
// host controller driving a cpu core's reset, nmi, match and return pins
//
// Overview of operation
// RULE_01: core clears its stack pointer to zero when reset is released.
// RULE_02: a valid stack pointer is loaded before any interrupt is accepted.
// RULE_03: no interrupt, nmi included, during the first instruction after reset.
// RULE_04: the stack pointer gets an even address for efficiency.
// RULE_05: core offers no control that can block the nmi pin.
// RULE_06: nmi pin reads back as an input-only port bit of its level.
// RULE_07: match target never on the first instruction of a service routine.
// RULE_08: no match target within seven instructions after a priority drop.
// RULE_09: no match target within three instructions after setting the i flag.
// RULE_10: no match target within three instructions after lowering ipl.
// RULE_11: routines rewriting control registers end with the flag-restore sequence.
// RULE_12: routines re-enabling nested interrupts also end with the restore sequence.
// RULE_13: if the nmi routine rewrites control registers, every routine restores.
// RULE_14: restore: select isp, push r0, read flag at offset 6, load, pop, nop, return.
// RULE_15: high-speed interrupts read the saved flag and use the fast return.
// RULE_16: core raises the match interrupt at the matched address.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
module irq_entry_host
  import irq_host_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic dev_rstn,
  output logic nmi_n,
  output logic sp_load,
  output logic [ADDR_W-1:0] sp_value,
  output logic match_en,
  output logic [ADDR_W-1:0] match_addr,
  output logic seq_valid,
  output logic [3:0] seq_op,
  output logic [3:0] seq_offset,
  input wire logic first_done,
  input wire logic retire_tgl,
  input wire logic [2:0] retire_kind,
  input wire logic [ADDR_W-1:0] retire_addr,
  input wire logic nmi_port_bit,
  input wire logic seq_ack
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam int SYNC_W = ADDR_W + 7;
  localparam int P_KIND = ADDR_W;
  localparam int P_TGL = ADDR_W + 3;
  localparam int P_FIRST = ADDR_W + 4;
  localparam int P_NMI = ADDR_W + 5;
  localparam int P_ACK = ADDR_W + 6;

  typedef enum logic [1:0] {N_IDLE, N_LOW, N_HIGH} nmi_state_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] f;
    logic last_tgl;
    logic dev_run;
    logic match_en;
    logic fast;
    logic nmi_rewrites;
    logic ret_go;
    logic sp_valid;
    logic sp_load;
    logic [ADDR_W-1:0] sp_value;
    logic [ADDR_W-1:0] match_addr;
    nmi_state_t nst;
    logic nmi_pend;
    logic nmi_n;
    logic [3:0] ncnt;
    logic [2:0] blackout;
    logic icr_touched;
    logic nested;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } host_reg_t;

  host_reg_t r;
  host_reg_t next_r;
  restore_if rif ();

  // --------------------
  // helper functions
  // --------------------
  // a change counts once the second and third stages agree
  function automatic logic [SYNC_W-1:0] settle(
    logic [SYNC_W-1:0] a, logic [SYNC_W-1:0] b, logic [SYNC_W-1:0] prev);
    settle = (a & ~(a ^ b)) | (prev & (a ^ b));
  endfunction

  function automatic logic mapped(logic [11:0] a);
    mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_INT_STAT) ||
             (a == REG_INT_MASK) || (a == REG_MATCH_ADDR) || (a == REG_SP_INIT);
  endfunction

  // a short window never cuts a longer one already running
  function automatic logic [2:0] widen(logic [2:0] cur, logic [2:0] win);
    widen = (cur < win) ? win : cur;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [SYNC_W-1:0] raw;
  logic retire_ev;
  logic ok_for_irq;
  logic apb_wr;
  logic [EV_W-1:0] ev;
  retire_kind_t kind;
  logic [ADDR_W-1:0] raddr;

  assign raw = {seq_ack, nmi_port_bit, first_done, retire_tgl, retire_kind, retire_addr};
  assign kind = retire_kind_t'(r.f[P_KIND +: 3]);
  assign raddr = r.f[ADDR_W-1:0];
  // one pulse per synced toggle of the retire pin
  assign retire_ev = r.f[P_TGL] ^ r.last_tgl;
  // nmi held back until the first instruction retired and sp is loaded
  assign ok_for_irq = r.dev_run && r.f[P_FIRST] && r.sp_valid; // RULE_02 RULE_03
  assign apb_wr = psel && penable && r.pready && pwrite;

  always_comb begin
    next_r = r;
    ev = '0;
    // --------------------
    // pin synchronisers
    // --------------------
    next_r.s1 = raw;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.f = settle(r.s2, r.s3, r.f);
    next_r.last_tgl = r.f[P_TGL];
    next_r.sp_load = 1'b0;
    next_r.ret_go = 1'b0;

    // --------------------
    // instruction retire tracking for the match blackout windows
    // --------------------
    if (retire_ev) begin
      if (r.match_en && raddr == r.match_addr &&
          (r.blackout != 3'h0 || kind == K_ISR_START)) begin
        ev[EV_MATCH_BAD] = 1'b1; // RULE_07 RULE_08 RULE_09 RULE_10
        next_r.match_en = 1'b0;
      end
      if (r.blackout != 3'h0) begin
        next_r.blackout = r.blackout - 3'h1;
      end
      case (kind)
        K_CLR_REQ, K_LOWER_ILVL: begin
          next_r.blackout = WIN_PRIO_DROP; // RULE_08
          next_r.icr_touched = 1'b1; // RULE_11
        end
        K_SET_I: begin
          next_r.blackout = widen(next_r.blackout, WIN_FLAG_SET); // RULE_09
          next_r.nested = 1'b1; // RULE_12
        end
        K_LOWER_IPL: begin
          next_r.blackout = widen(next_r.blackout, WIN_FLAG_SET); // RULE_10
        end
        default: begin
        end
      endcase
    end

    // --------------------
    // nmi pulse: low and high phases each held the minimum width
    // --------------------
    case (r.nst)
      N_IDLE: begin
        if (r.nmi_pend && ok_for_irq) begin
          next_r.nmi_pend = 1'b0;
          next_r.nmi_n = 1'b0;
          next_r.ncnt = NMI_HOLD;
          next_r.nst = N_LOW;
          ev[EV_NMI_SENT] = 1'b1;
        end
      end
      N_LOW: begin
        next_r.ncnt = r.ncnt - 4'h1;
        if (r.ncnt == 4'h1) begin
          next_r.nmi_n = 1'b1;
          next_r.ncnt = NMI_HOLD;
          next_r.nst = N_HIGH;
        end
      end
      N_HIGH: begin
        next_r.ncnt = r.ncnt - 4'h1;
        if (r.ncnt == 4'h1) begin
          next_r.nst = N_IDLE;
        end
      end
      default: next_r.nst = N_IDLE;
    endcase

    // --------------------
    // restore sequence finished
    // --------------------
    if (rif.done) begin
      ev[EV_SEQ_DONE] = 1'b1;
      next_r.icr_touched = 1'b0;
      next_r.nested = 1'b0;
    end

    // --------------------
    // apb: setup cycle registers the answer, access cycle completes
    // --------------------
    next_r.pready = psel && !r.pready;
    // error flag stands for the access cycle only
    next_r.pslverr = 1'b0;
    if (psel && !penable && !r.pready) begin
      next_r.pslverr = !mapped(paddr);
      next_r.prdata = '0;
      case (paddr)
        REG_CTRL: begin
          next_r.prdata[CTRL_DEV_RUN] = r.dev_run;
          next_r.prdata[CTRL_NMI_REQ] = r.nmi_pend;
          next_r.prdata[CTRL_MATCH_EN] = r.match_en;
          next_r.prdata[CTRL_FAST] = r.fast;
          next_r.prdata[CTRL_NMI_REWRITES] = r.nmi_rewrites;
        end
        REG_STATUS: begin
          next_r.prdata[ST_FIRST_DONE] = r.f[P_FIRST];
          next_r.prdata[ST_SP_VALID] = r.sp_valid;
          next_r.prdata[ST_NMI_PIN] = r.f[P_NMI]; // RULE_06
          next_r.prdata[ST_BLACKOUT] = (r.blackout != 3'h0);
          next_r.prdata[ST_SEQ_BUSY] = rif.busy;
          next_r.prdata[ST_NMI_PEND] = r.nmi_pend;
        end
        REG_INT_STAT: next_r.prdata[EV_W-1:0] = r.stat;
        REG_INT_MASK: next_r.prdata[EV_W-1:0] = r.mask;
        REG_MATCH_ADDR: next_r.prdata[ADDR_W-1:0] = r.match_addr;
        REG_SP_INIT: next_r.prdata[ADDR_W-1:0] = r.sp_value;
        default: next_r.prdata = '0;
      endcase
    end

    // --------------------
    // register writes and sticky events
    // --------------------
    next_r.stat = r.stat | ev;
    if (apb_wr) begin
      case (paddr)
        REG_CTRL: begin
          next_r.dev_run = pwdata[CTRL_DEV_RUN];
          next_r.match_en = pwdata[CTRL_MATCH_EN];
          next_r.fast = pwdata[CTRL_FAST];
          next_r.nmi_rewrites = pwdata[CTRL_NMI_REWRITES];
          // a send in this cycle must not be undone by the write
          next_r.nmi_pend = next_r.nmi_pend | pwdata[CTRL_NMI_REQ];
          next_r.ret_go = pwdata[CTRL_RET_GO] && !rif.busy;
        end
        // an event in the same cycle survives its clear
        REG_INT_STAT: next_r.stat = (r.stat & ~pwdata[EV_W-1:0]) | ev;
        REG_INT_MASK: next_r.mask = pwdata[EV_W-1:0];
        REG_MATCH_ADDR: next_r.match_addr = pwdata[ADDR_W-1:0];
        REG_SP_INIT: begin
          // low bit forced clear, odd stack addresses cost bus cycles
          next_r.sp_value = {pwdata[ADDR_W-1:1], 1'b0}; // RULE_04
          next_r.sp_load = r.dev_run;
          next_r.sp_valid = r.dev_run; // RULE_02
        end
        default: begin
        end
      endcase
    end

    // --------------------
    // core in reset: its stack pointer reads zero again
    // --------------------
    if (!r.dev_run) begin
      next_r.sp_valid = 1'b0; // RULE_01
      next_r.blackout = 3'h0;
      next_r.icr_touched = 1'b0;
      next_r.nested = 1'b0;
    end

    // --------------------
    // level interrupt output
    // --------------------
    next_r.irq = |(next_r.stat & next_r.mask);
  end

  // ----------------------------------------
  // registers and sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.nmi_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // --------------------
  // restore sequencer link
  // --------------------
  // full restore when a control register was rewritten or nesting enabled
  assign rif.go = r.ret_go;
  assign rif.full = r.icr_touched || r.nested || r.nmi_rewrites; // RULE_11 RULE_12 RULE_13
  assign rif.fast = r.fast; // RULE_15
  assign rif.ack = r.f[P_ACK];

  restore_seq restore_seq_inst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .rif(rif.seq)
  );

  // ----------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign dev_rstn = r.dev_run;
  assign nmi_n = r.nmi_n;
  assign sp_load = r.sp_load;
  assign sp_value = r.sp_value;
  assign match_en = r.match_en;
  assign match_addr = r.match_addr;
  assign seq_valid = rif.valid;
  assign seq_op = rif.op;
  assign seq_offset = rif.offset;

endmodule

//--- irq_entry_host_assertions.sv
// concurrent checks on the interrupt entry host controller ports
`timescale 1ns/100ps
module irq_entry_host_assertions
  import irq_host_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dev_rstn,
  input wire logic nmi_n,
  input wire logic sp_load,
  input wire logic [ADDR_W-1:0] sp_value,
  input wire logic seq_valid,
  input wire logic [3:0] seq_op,
  input wire logic [3:0] seq_offset,
  input wire logic first_done,
  input wire logic seq_ack
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic sp_seen;
  logic [3:0] prev_op;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // sp_seen drops with core reset: a load before that no longer counts
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sp_seen <= 1'b0;
      prev_op <= 4'h0;
    end else begin
      sp_seen <= dev_rstn && (sp_seen || sp_load);
      if (seq_valid) begin
        prev_op <= seq_op;
      end
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sp_even_a: assert property (sp_load |-> !sp_value[0])
    else $error("odd stack pointer loaded");
  nmi_first_a: assert property ($fell(nmi_n) |-> first_done && dev_rstn)
    else $error("nmi during first instruction");
  nmi_sp_a: assert property ($fell(nmi_n) |-> sp_seen)
    else $error("nmi before stack pointer load");
  nmi_low_a: assert property ($fell(nmi_n) |-> (!nmi_n) [*5] ##1 nmi_n)
    else $error("nmi low pulse width wrong");
  nmi_gap_a: assert property ($rose(nmi_n) |-> nmi_n [*5])
    else $error("nmi high gap too short");
  seq_hold_a: assert property (seq_valid && !seq_ack |=> seq_valid && $stable(seq_op))
    else $error("restore op dropped before ack");
  seq_offset_a: assert property (seq_valid && seq_op == OP_READ_STACK_FLAG
    |-> seq_offset == STACK_FLAG_OFFSET)
    else $error("stacked flag offset wrong");
  seq_push_a: assert property ($rose(seq_valid) && seq_op == OP_PUSH_R0
    |-> prev_op == OP_SEL_ISP)
    else $error("push not after stack select");
  seq_fast_a: assert property ($rose(seq_valid) && seq_op == OP_FAST_RETURN
    |-> prev_op == OP_NOP)
    else $error("fast return not after nop");
  apb_err_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access phase");
  cover property ($fell(nmi_n));
  cover property (sp_load);
  cover property ($rose(seq_valid) && seq_op == OP_FAST_RETURN);
endmodule

//--- irq_entry_host_bench.sv
// self-checking bench for the interrupt entry host controller
`timescale 1ns/100ps
module irq_entry_host_bench;
  import irq_host_pkg::*;
  logic sys_clk, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_val;
  logic pready, pslverr, irq, dev_rstn, nmi_n, sp_load, match_en, seq_valid, first_done;
  logic nmi_port_bit, seq_ack, rd_err, retire_tgl = 1'b0, slow = 1'b0;
  logic [23:0] sp_value, match_addr, retire_addr = 24'h0;
  logic [3:0] seq_op, seq_offset;
  logic [2:0] retire_kind = 3'h0;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  irq_entry_host irq_entry_host_inst (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .dev_rstn, .nmi_n, .sp_load, .sp_value,
    .match_en, .match_addr, .seq_valid, .seq_op, .seq_offset, .first_done, .retire_tgl,
    .retire_kind, .retire_addr, .nmi_port_bit, .seq_ack);
  core_model core_model_inst (.sys_clk, .dev_rstn, .nmi_n, .sp_load, .sp_value, .match_en,
    .match_addr, .retire_tgl, .retire_addr, .seq_valid, .seq_op, .slow, .first_done,
    .nmi_port_bit, .seq_ack);
  // ----------------------------------------
  // clock, timeout, verdict
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // whole run needs under two thousand cycles; a hang stops well after
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd_val & m);
  endtask
  task automatic retire(input retire_kind_t k, input logic [23:0] a);
    @(posedge sys_clk);
    retire_kind <= k;
    retire_addr <= a;
    @(posedge sys_clk);
    retire_tgl <= ~retire_tgl;
    repeat (6) @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("core held in reset", 1'b0, dev_rstn);
    chk("nmi idle", 1'b1, nmi_n);
    rdc("ctrl reset", REG_CTRL, 32'hffff_ffff, 32'h0);
    rdc("int_stat reset", REG_INT_STAT, 32'hffff_ffff, 32'h0);
    rdc("int_mask reset", REG_INT_MASK, 32'hffff_ffff, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 1'b1, rd_err);
    chk("unmapped data", 32'h0, rd_val);
  endtask
  task automatic t_nmi;
    apb(1'b1, REG_CTRL, 32'h2);
    repeat (20) @(posedge sys_clk);
    chk("nmi with core in reset", 32'h0, core_model_inst.nmi_count);
    rdc("nmi pending", REG_STATUS, 32'h20, 32'h20);
    apb(1'b1, REG_CTRL, 32'h3);
    repeat (20) @(posedge sys_clk);
    chk("nmi before sp load", 32'h0, core_model_inst.nmi_count);
    chk("sp after reset", 32'h0, core_model_inst.sp);
    apb(1'b1, REG_INT_MASK, 32'h1);
    apb(1'b1, REG_SP_INIT, 32'h12_3457);
    repeat (20) @(posedge sys_clk);
    chk("sp loaded even", 32'h12_3456, core_model_inst.sp);
    rdc("sp readback", REG_SP_INIT, 32'hffff_ffff, 32'h12_3456);
    chk("nmi taken", 32'h1, core_model_inst.nmi_count);
    chk("irq on nmi", 1'b1, irq);
    rdc("nmi pin readback", REG_STATUS, 32'h4, 32'h4);
    apb(1'b1, REG_INT_MASK, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq masked", 1'b0, irq);
    apb(1'b1, REG_INT_MASK, 32'h1);
    apb(1'b1, REG_INT_STAT, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 1'b0, irq);
    rdc("nmi flag cleared", REG_INT_STAT, 32'h1, 32'h0);
  endtask
  task automatic run_seq(input logic [31:0] c, input logic [27:0] e, input int n);
    core_model_inst.ops.delete();
    apb(1'b1, REG_CTRL, c | 32'h11);
    for (int i = 0; i < 600; i++) begin
      if (core_model_inst.ops.size() == n && seq_ack === 1'b0) break;
      @(posedge sys_clk);
    end
    repeat (8) @(posedge sys_clk);
    rdc("restore done", REG_INT_STAT, 32'h2, 32'h2);
    chk("restore op count", n, core_model_inst.ops.size());
    for (int i = 0; i < n; i++) chk("restore op", e[4*i +: 4], core_model_inst.ops[i]);
    apb(1'b1, REG_INT_STAT, 32'h2);
  endtask
  task automatic t_match;
    retire_kind_t kk[8] = '{K_CLR_REQ, K_CLR_REQ, K_LOWER_ILVL, K_LOWER_ILVL, K_SET_I,
                            K_LOWER_IPL, K_ISR_START, K_NONE};
    int gg[8] = '{6, 7, 6, 7, 2, 2, 0, 0};
    logic [7:0] ee = 8'h75;
    int hh;
    apb(1'b1, REG_MATCH_ADDR, 32'h100);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, REG_CTRL, 32'h5);
      repeat (8) retire(K_NONE, 24'h200);
      apb(1'b1, REG_INT_STAT, 32'h4);
      hh = core_model_inst.hits;
      retire(kk[i], kk[i] == K_ISR_START ? 24'h100 : 24'h200);
      if (kk[i] != K_ISR_START) begin
        repeat (gg[i]) retire(K_NONE, 24'h200);
        retire(K_NONE, 24'h100);
      end
      rdc("match guard", REG_INT_STAT, 32'h4, {29'h0, ee[i], 2'h0});
      chk("match enable", !ee[i], match_en);
      chk("match hit", hh + 1, core_model_inst.hits);
    end
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_nmi();
    run_seq(32'h1, 28'h8, 1);
    slow <= 1'b1;
    run_seq(32'h21, 28'h876_5321, 7);
    slow <= 1'b0;
    run_seq(32'h29, 28'h976_5421, 7);
    t_match();
    run_seq(32'h1, 28'h876_5321, 7);
    print_verdict();
  end
endmodule
bind irq_entry_host irq_entry_host_assertions #(.ADDR_W(ADDR_W)) irq_entry_host_assertions_inst (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .dev_rstn(dev_rstn), .nmi_n(nmi_n), .sp_load(sp_load),
  .sp_value(sp_value), .seq_valid(seq_valid), .seq_op(seq_op), .seq_offset(seq_offset),
  .first_done(first_done), .seq_ack(seq_ack));

//--- irq_host_pkg.sv
// constants and types shared by the interrupt entry host controller
package irq_host_pkg;

  // ----------------------------------------
  // register map, byte offsets on apb
  // ----------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_INT_STAT = 12'h008;
  localparam logic [11:0] REG_INT_MASK = 12'h00c;
  localparam logic [11:0] REG_MATCH_ADDR = 12'h010;
  localparam logic [11:0] REG_SP_INIT = 12'h014;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_DEV_RUN = 0;
  localparam int CTRL_NMI_REQ = 1;
  localparam int CTRL_MATCH_EN = 2;
  localparam int CTRL_FAST = 3;
  localparam int CTRL_RET_GO = 4;
  localparam int CTRL_NMI_REWRITES = 5;
  localparam int ST_FIRST_DONE = 0;
  localparam int ST_SP_VALID = 1;
  localparam int ST_NMI_PIN = 2;
  localparam int ST_BLACKOUT = 3;
  localparam int ST_SEQ_BUSY = 4;
  localparam int ST_NMI_PEND = 5;
  localparam int EV_NMI_SENT = 0;
  localparam int EV_SEQ_DONE = 1;
  localparam int EV_MATCH_BAD = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int NMI_EXTRA_NS = 300;
  localparam int NMI_DEV_CLKS = 2;
  localparam int NMI_HOLD_CYC =
    (NMI_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + NMI_DEV_CLKS;
  localparam logic [3:0] NMI_HOLD = 4'(NMI_HOLD_CYC);

  // ----------------------------------------
  // address-match blackout windows and the stacked flag offset
  // ----------------------------------------
  localparam logic [2:0] WIN_PRIO_DROP = 3'h7;
  localparam logic [2:0] WIN_FLAG_SET = 3'h3;
  localparam logic [3:0] STACK_FLAG_OFFSET = 4'h6;

  // class of each retired instruction, reported by the core
  typedef enum logic [2:0] {
    K_NONE, K_CLR_REQ, K_LOWER_ILVL, K_SET_I, K_LOWER_IPL, K_ISR_START
  } retire_kind_t;

  // operation fed to the core by the restore sequencer
  typedef enum logic [3:0] {
    OP_IDLE, OP_SEL_ISP, OP_PUSH_R0, OP_READ_STACK_FLAG, OP_READ_SAVED_FLAG,
    OP_LOAD_FLAG, OP_POP_R0, OP_NOP, OP_RETURN, OP_FAST_RETURN
  } seq_op_t;

endpackage

//--- restore_if.sv
// link between the controller and its flag-restore sequencer
`timescale 1ns/100ps
interface restore_if;
  import irq_host_pkg::*;
  logic go;
  logic full;
  logic fast;
  logic ack;
  logic busy;
  logic done;
  logic valid;
  seq_op_t op;
  logic [3:0] offset;
  modport ctl(output go, output full, output fast, output ack,
              input busy, input done, input valid, input op, input offset);
  modport seq(input go, input full, input fast, input ack,
              output busy, output done, output valid, output op, output offset);
endinterface

//--- restore_seq.sv
// flag-restore and return sequencer, four-phase handshake per operation
`timescale 1ns/100ps
module restore_seq
  import irq_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  restore_if.seq rif
);

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_RELEASE} seq_state_t;

  typedef struct packed {
    seq_state_t st;
    seq_op_t op;
    logic fast;
    logic valid;
    logic busy;
    logic done;
    logic [3:0] offset;
  } seq_reg_t;

  seq_reg_t r;
  seq_reg_t next_r;

  // order of the restore operations after the register pops
  function automatic seq_op_t step_after(seq_op_t cur, logic fast);
    case (cur)
      OP_SEL_ISP: step_after = OP_PUSH_R0;
      OP_PUSH_R0: step_after = fast ? OP_READ_SAVED_FLAG : OP_READ_STACK_FLAG; // RULE_15
      OP_READ_STACK_FLAG: step_after = OP_LOAD_FLAG;
      OP_READ_SAVED_FLAG: step_after = OP_LOAD_FLAG;
      OP_LOAD_FLAG: step_after = OP_POP_R0;
      OP_POP_R0: step_after = OP_NOP;
      OP_NOP: step_after = fast ? OP_FAST_RETURN : OP_RETURN; // RULE_15
      default: step_after = OP_IDLE;
    endcase
  endfunction

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.st)
      S_IDLE: begin
        if (rif.go) begin
          next_r.fast = rif.fast;
          next_r.busy = 1'b1;
          next_r.valid = 1'b1;
          next_r.st = S_ISSUE;
          // plain return when no control register was touched and no nesting or nmi rewrite is flagged
          if (rif.full) begin
            next_r.op = OP_SEL_ISP; // RULE_14
          end else begin
            next_r.op = rif.fast ? OP_FAST_RETURN : OP_RETURN;
          end
        end
      end
      S_ISSUE: begin
        if (rif.ack) begin
          next_r.valid = 1'b0;
          next_r.st = S_RELEASE;
        end
      end
      S_RELEASE: begin
        if (!rif.ack) begin
          if (r.op == OP_RETURN || r.op == OP_FAST_RETURN) begin
            next_r.op = OP_IDLE;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.st = S_IDLE;
          end else begin
            next_r.op = step_after(r.op, r.fast); // RULE_14
            next_r.valid = 1'b1;
            next_r.st = S_ISSUE;
          end
        end
      end
      default: next_r.st = S_IDLE;
    endcase
    next_r.offset = (next_r.op == OP_READ_STACK_FLAG) ? STACK_FLAG_OFFSET : 4'h0; // RULE_14
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rif.busy = r.busy;
  assign rif.done = r.done;
  assign rif.valid = r.valid;
  assign rif.op = r.op;
  assign rif.offset = r.offset;

endmodule
